// [hw/sms_core.sv]
// Purpose: Byte-wide full-duplex serial port, master or slave, on Wishbone.
// Assumes: clk_i at 100 MHz; link pins sampled through two flip-flops.
// Notes:   Control at 0x0, status at 0x4, data at 0x8; one wait state per access.
//
// Added by the designer: the Wishbone slave port and the register addresses.
`default_nettype none
`include "sms_defs.svh"

module sms_core
	import sms_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        cpu_mask_i,
	output logic             irq_o,
	sms_link_if.dev          link
);

	////////////////////////////////////////////////////////////////////////////////
	// Rate decode
	function automatic logic [5:0] half_reload(input logic [2:0] code);
		case (code)
			`SMS_RATE_D2:  half_reload = `SMS_HALF_D2;
			`SMS_RATE_D8:  half_reload = `SMS_HALF_D8;
			`SMS_RATE_D16: half_reload = `SMS_HALF_D16;
			`SMS_RATE_D32: half_reload = `SMS_HALF_D32;
			default:       half_reload = `SMS_HALF_D64;
		endcase
	endfunction : half_reload

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; logic reads the second stage and, for the clock, also sck_p_r after it
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic       sck_p_r;
	logic       sck_s;
	logic       mosi_s;
	logic       miso_s;
	logic       ss_s;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= {`SMS_SCK_PULL, 3'h7};
			sync2_r <= {`SMS_SCK_PULL, 3'h7};
			sck_p_r <= `SMS_SCK_PULL;
		end else begin
			sync1_r <= {link.sck, link.mosi, link.miso, link.ss_n};
			sync2_r <= sync1_r;
			sck_p_r <= sync2_r[3];
		end
	end

	assign sck_s  = sync2_r[3];
	assign mosi_s = sync2_r[2];
	assign miso_s = sync2_r[1];
	assign ss_s   = sync2_r[0];

	////////////////////////////////////////////////////////////////////////////////
	// State
	sms_state_t st_r,     st_nxt;
	logic [7:0] ctrl_r,   ctrl_nxt;
	logic       done_r,   done_nxt;
	logic       coll_r,   coll_nxt;
	logic       armed_r,  armed_nxt;
	logic [7:0] sr_r,     sr_nxt;
	logic [7:0] rxbuf_r,  rxbuf_nxt;
	logic       dout_r,   dout_nxt;
	logic [3:0] edge_r,   edge_nxt;
	logic [5:0] div_r,    div_nxt;
	logic       msck_r,   msck_nxt;
	logic       ack_r,    ack_nxt;
	logic [7:0] rdat_r,   rdat_nxt;

	logic is_master;
	logic pen;
	logic clock_idle_level;
	logic capture_edge_select;
	logic req;
	logic wr;
	logic busy;
	logic sck_edge;
	logic lead;
	logic launch;
	logic din;
	logic [7:0] captured;

	assign is_master = ctrl_r[`SMS_CB_MASTER_SELECT];
	assign pen       = ctrl_r[`SMS_CB_PEN];
	assign clock_idle_level      = ctrl_r[`SMS_CB_CLOCK_IDLE_LEVEL];
	assign capture_edge_select      = ctrl_r[`SMS_CB_CAPTURE_EDGE_SELECT];
	assign req       = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr        = req && wb_we_i && wb_sel_i[0];
	// With phase clear a selected slave is already frozen before any edge
	assign busy      = (st_r == SMS_SHIFT) || (st_r == SMS_ARMED && !capture_edge_select);
	assign sck_edge  = is_master ? (st_r == SMS_SHIFT && div_r == 6'h00) : (sck_s != sck_p_r);
	assign lead      = is_master ? (msck_r == clock_idle_level) : (sck_p_r == clock_idle_level);
	assign launch    = sms_launch(capture_edge_select, lead);
	assign din       = is_master ? miso_s : mosi_s;
	assign captured  = {sr_r[6:0], din};

	always_comb begin
		st_nxt    = st_r;
		ctrl_nxt  = ctrl_r;
		done_nxt  = done_r;
		coll_nxt  = coll_r;
		armed_nxt = armed_r;
		sr_nxt    = sr_r;
		rxbuf_nxt = rxbuf_r;
		dout_nxt  = dout_r;
		edge_nxt  = edge_r;
		div_nxt   = div_r;
		msck_nxt  = msck_r;
		ack_nxt   = req;
		rdat_nxt  = rdat_r;

		// Register access
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				`SMS_OFF_CTRL: rdat_nxt = ctrl_r;
				`SMS_OFF_STAT: rdat_nxt = {done_r, coll_r, 6'h00};
				`SMS_OFF_DATA: rdat_nxt = rxbuf_r;
				default:       rdat_nxt = 8'h00;
			endcase
		end
		if (req && wb_adr_i == `SMS_OFF_STAT && (done_r || coll_r)) begin
			armed_nxt = 1'b1;
		end
		if (req && wb_adr_i == `SMS_OFF_DATA && armed_r) begin
			done_nxt  = 1'b0;
			coll_nxt  = 1'b0;
			armed_nxt = 1'b0;
		end
		if (wr && wb_adr_i == `SMS_OFF_CTRL) begin
			ctrl_nxt = wb_dat_i[7:0];
		end
		if (wr && wb_adr_i == `SMS_OFF_DATA) begin
			if (busy) begin
				coll_nxt = 1'b1;
			end else if (!(done_r && !armed_r)) begin
				sr_nxt = wb_dat_i[7:0];
				if (is_master && pen) begin
					st_nxt   = SMS_SHIFT;
					edge_nxt = 4'h0;
					div_nxt  = half_reload({ctrl_r[`SMS_CB_RATEC], ctrl_r[`SMS_CB_RATEB],
					                        ctrl_r[`SMS_CB_RATEA]});
					msck_nxt = clock_idle_level;
				end
			end
		end

		// Shift engine
		if (st_r == SMS_IDLE && !is_master && pen && !ss_s) begin
			st_nxt   = SMS_ARMED;
			edge_nxt = 4'h0;
		end
		if (is_master && st_r == SMS_SHIFT) begin
			if (div_r == 6'h00) begin
				div_nxt  = half_reload({ctrl_r[`SMS_CB_RATEC], ctrl_r[`SMS_CB_RATEB],
				                        ctrl_r[`SMS_CB_RATEA]});
				msck_nxt = !msck_r;
			end else begin
				div_nxt = div_r - 6'h01;
			end
		end
		if (sck_edge && (st_r == SMS_SHIFT || (st_r == SMS_ARMED && !is_master))) begin
			st_nxt = SMS_SHIFT;
			if (launch) begin
				dout_nxt = sr_r[7];
			end else begin
				sr_nxt = captured;
			end
			edge_nxt = edge_r + 4'h1;
			if (edge_r == `SMS_EDGE_LAST) begin
				done_nxt  = 1'b1;
				armed_nxt = 1'b0;
				rxbuf_nxt = launch ? sr_r : captured;
				st_nxt    = is_master ? SMS_IDLE : SMS_ARMED;
			end
		end
		if (st_r != SMS_SHIFT) begin
			dout_nxt = sr_nxt[7];
		end

		// Slave deselect ends the byte; master with select low drops its mode
		if (!is_master && (ss_s || !pen) && st_r != SMS_IDLE) begin
			st_nxt = SMS_IDLE;
		end
		if (is_master && !ss_s) begin
			ctrl_nxt[`SMS_CB_MASTER_SELECT] = 1'b0;
			ctrl_nxt[`SMS_CB_PEN]  = 1'b0;
			st_nxt                 = SMS_IDLE;
			msck_nxt               = clock_idle_level;
		end
		if (is_master && st_r == SMS_IDLE) begin
			msck_nxt = ctrl_nxt[`SMS_CB_CLOCK_IDLE_LEVEL];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r    <= SMS_IDLE;
			ctrl_r  <= `SMS_CTRL_RST;
			done_r  <= 1'b0;
			coll_r  <= 1'b0;
			armed_r <= 1'b0;
			sr_r    <= 8'h00;
			rxbuf_r <= 8'h00;
			dout_r  <= 1'b0;
			edge_r  <= 4'h0;
			div_r   <= 6'h00;
			msck_r  <= 1'b0;
			ack_r   <= 1'b0;
			rdat_r  <= 8'h00;
		end else begin
			st_r    <= st_nxt;
			ctrl_r  <= ctrl_nxt;
			done_r  <= done_nxt;
			coll_r  <= coll_nxt;
			armed_r <= armed_nxt;
			sr_r    <= sr_nxt;
			rxbuf_r <= rxbuf_nxt;
			dout_r  <= dout_nxt;
			edge_r  <= edge_nxt;
			div_r   <= div_nxt;
			msck_r  <= msck_nxt;
			ack_r   <= ack_nxt;
			rdat_r  <= rdat_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign wb_ack_o = ack_r;
	assign wb_dat_o = {24'h000000, rdat_r};
	// Collision never reaches the interrupt
	assign irq_o    = done_r && ctrl_r[`SMS_CB_IRQEN] && !cpu_mask_i;

	assign link.dev_sck_o    = msck_r;
	assign link.dev_sck_oe_n = !(is_master && pen);
	assign link.dev_mosi_o   = dout_r;
	assign link.dev_mosi_oe_n = !(is_master && pen);
	assign link.dev_miso_o   = dout_r;
	// Phase set: select alone does not drive MISO until the first edge
	assign link.dev_miso_oe_n = !(!is_master && pen && !ss_s &&
	                              (!capture_edge_select || st_r == SMS_SHIFT));

endmodule : sms_core

`default_nettype wire

// [hw/sms_defs.svh]
// Purpose: Shared constants of the serial port shifter and its partner.
// Assumes: Byte offsets on a 32-bit Wishbone bus, data in the low byte.
// Notes:   Definitions only.
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH

// Register byte offsets
`define SMS_OFF_CTRL     4'h0
`define SMS_OFF_STAT     4'h4
`define SMS_OFF_DATA     4'h8

// Control register fields
`define SMS_CB_IRQEN     7
`define SMS_CB_PEN       6
`define SMS_CB_RATEC     5
`define SMS_CB_MASTER_SELECT      4
`define SMS_CB_CLOCK_IDLE_LEVEL      3
`define SMS_CB_CAPTURE_EDGE_SELECT      2
`define SMS_CB_RATEB     1
`define SMS_CB_RATEA     0
`define SMS_CTRL_RST     8'h00

// Status register fields
`define SMS_SB_DONE      7
`define SMS_SB_COLL      6

// Index of the last of the sixteen clock edges of a byte
`define SMS_EDGE_LAST    4'hF

// Half-period reload values of the master divider (reload + 1 cycles)
`define SMS_HALF_D2      6'h00
`define SMS_HALF_D8      6'h03
`define SMS_HALF_D16     6'h07
`define SMS_HALF_D32     6'h0F
`define SMS_HALF_D64     6'h1F

// Rate codes {rate_c, rate_sel_b, rate_sel_a}
`define SMS_RATE_D2      3'h4
`define SMS_RATE_D8      3'h0
`define SMS_RATE_D16     3'h1
`define SMS_RATE_D32     3'h6
`define SMS_RATE_D64     3'h2

// Level of an undriven line
`define SMS_PULL_LEVEL   1'b1
`define SMS_SCK_PULL     1'b0

`endif

// [hw/sms_link_if.sv]
// Purpose: Four-wire serial link joining the device end and the partner end.
// Assumes: Enables are active low; an undriven line takes its pull level.
// Notes:   The wire levels are resolved here, not in the ends.
`default_nettype none
`include "sms_defs.svh"

interface sms_link_if;
	logic dev_sck_o;
	logic dev_sck_oe_n;
	logic dev_mosi_o;
	logic dev_mosi_oe_n;
	logic dev_miso_o;
	logic dev_miso_oe_n;
	logic ptn_sck_o;
	logic ptn_sck_oe_n;
	logic ptn_mosi_o;
	logic ptn_mosi_oe_n;
	logic ptn_miso_o;
	logic ptn_miso_oe_n;
	logic ptn_ss_n_o;
	logic ptn_ss_n_oe_n;
	logic sck;
	logic mosi;
	logic miso;
	logic ss_n;

	assign sck  = !dev_sck_oe_n  ? dev_sck_o  : (!ptn_sck_oe_n  ? ptn_sck_o  : `SMS_SCK_PULL);
	assign mosi = !dev_mosi_oe_n ? dev_mosi_o : (!ptn_mosi_oe_n ? ptn_mosi_o : `SMS_PULL_LEVEL);
	assign miso = !dev_miso_oe_n ? dev_miso_o : (!ptn_miso_oe_n ? ptn_miso_o : `SMS_PULL_LEVEL);
	assign ss_n = !ptn_ss_n_oe_n ? ptn_ss_n_o : `SMS_PULL_LEVEL;

	modport dev (
		input  sck, mosi, miso, ss_n,
		output dev_sck_o, dev_sck_oe_n, dev_mosi_o, dev_mosi_oe_n, dev_miso_o, dev_miso_oe_n
	);

	modport ptn (
		input  sck, mosi, miso,
		output ptn_sck_o, ptn_sck_oe_n, ptn_mosi_o, ptn_mosi_oe_n, ptn_miso_o, ptn_miso_oe_n,
		output ptn_ss_n_o, ptn_ss_n_oe_n
	);
endinterface : sms_link_if

`default_nettype wire

// [hw/sms_partner.sv]
// Purpose: External end of the serial link, as master or as slave.
// Assumes: Same clock domain rate as the device; link pins synchronised.
// Notes:   As slave it is always selected and counts edges from its last load.
`default_nettype none
`include "sms_defs.svh"

module sms_partner
	import sms_pkg::*;
#(
	parameter logic [7:0] HALF_RELOAD = 8'h05
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       role_master_i,
	input  wire logic       clock_idle_level_i,
	input  wire logic       capture_edge_select_i,
	input  wire logic       start_i,
	input  wire logic [7:0] tx_byte_i,
	output logic      [7:0] rx_byte_o,
	output logic            done_o,
	output logic            busy_o,
	sms_link_if.ptn         link
);

	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic       sck_p_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
			sck_p_r <= 1'b0;
		end else begin
			sync1_r <= {link.sck, link.mosi, link.miso};
			sync2_r <= sync1_r;
			sck_p_r <= sync2_r[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	sms_state_t st_r,   st_nxt;
	logic [7:0] sr_r,   sr_nxt;
	logic [7:0] rx_r,   rx_nxt;
	logic       done_r, done_nxt;
	logic       dout_r, dout_nxt;
	logic       sck_r,  sck_nxt;
	logic       ssn_r,  ssn_nxt;
	logic [3:0] edge_r, edge_nxt;
	logic [7:0] div_r,  div_nxt;

	logic tick;
	logic sck_edge;
	logic lead;
	logic launch;
	logic din;

	assign tick     = (div_r == 8'h00);
	assign sck_edge = role_master_i ? (st_r == SMS_SHIFT && tick) : (sync2_r[2] != sck_p_r);
	assign lead     = role_master_i ? (sck_r == clock_idle_level_i) : (sck_p_r == clock_idle_level_i);
	assign launch   = sms_launch(capture_edge_select_i, lead);
	assign din      = role_master_i ? sync2_r[0] : sync2_r[1];

	always_comb begin
		st_nxt   = st_r;
		sr_nxt   = sr_r;
		rx_nxt   = rx_r;
		done_nxt = 1'b0;
		dout_nxt = dout_r;
		sck_nxt  = sck_r;
		ssn_nxt  = ssn_r;
		edge_nxt = edge_r;
		div_nxt  = tick ? HALF_RELOAD : div_r - 8'h01;

		if (start_i && st_r == SMS_IDLE) begin
			sr_nxt   = tx_byte_i;
			dout_nxt = tx_byte_i[7];
			edge_nxt = 4'h0;
			div_nxt  = HALF_RELOAD;
			sck_nxt  = clock_idle_level_i;
			if (role_master_i) begin
				st_nxt  = SMS_ARMED;
				ssn_nxt = 1'b0;
			end
		end
		if (role_master_i && st_r == SMS_ARMED && tick) begin
			st_nxt = SMS_SHIFT;
		end
		if (role_master_i && st_r == SMS_SHIFT && tick) begin
			sck_nxt = !sck_r;
		end
		if (sck_edge) begin
			if (launch) begin
				dout_nxt = sr_r[7];
			end else begin
				sr_nxt = {sr_r[6:0], din};
			end
			edge_nxt = edge_r + 4'h1;
			if (edge_r == `SMS_EDGE_LAST) begin
				done_nxt = 1'b1;
				rx_nxt   = launch ? sr_r : {sr_r[6:0], din};
				if (role_master_i) begin
					st_nxt  = SMS_IDLE;
					ssn_nxt = 1'b1;
				end
			end
		end
		if (!role_master_i) begin
			st_nxt  = SMS_IDLE;
			ssn_nxt = 1'b1;
			sck_nxt = clock_idle_level_i;
		end else if (st_r == SMS_IDLE && !start_i) begin
			sck_nxt = clock_idle_level_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r   <= SMS_IDLE;
			sr_r   <= 8'h00;
			rx_r   <= 8'h00;
			done_r <= 1'b0;
			dout_r <= 1'b0;
			sck_r  <= 1'b0;
			ssn_r  <= 1'b1;
			edge_r <= 4'h0;
			div_r  <= 8'h00;
		end else begin
			st_r   <= st_nxt;
			sr_r   <= sr_nxt;
			rx_r   <= rx_nxt;
			done_r <= done_nxt;
			dout_r <= dout_nxt;
			sck_r  <= sck_nxt;
			ssn_r  <= ssn_nxt;
			edge_r <= edge_nxt;
			div_r  <= div_nxt;
		end
	end

	assign rx_byte_o          = rx_r;
	assign done_o             = done_r;
	assign busy_o             = (st_r != SMS_IDLE);
	assign link.ptn_sck_o     = sck_r;
	assign link.ptn_sck_oe_n  = !role_master_i;
	assign link.ptn_mosi_o    = dout_r;
	assign link.ptn_mosi_oe_n = !role_master_i;
	assign link.ptn_miso_o    = dout_r;
	assign link.ptn_miso_oe_n = role_master_i;
	assign link.ptn_ss_n_o    = ssn_r;
	assign link.ptn_ss_n_oe_n = !role_master_i;

endmodule : sms_partner

`default_nettype wire

// [hw/sms_pkg.sv]
// Purpose: Types and shared decoding for both ends of the serial link.
// Assumes: Nothing beyond the constants header.
// Notes:   States are Gray coded along idle, armed, shift.
`default_nettype none

package sms_pkg;

	typedef enum logic [1:0] {
		SMS_IDLE  = 2'b00,
		SMS_ARMED = 2'b01,
		SMS_SHIFT = 2'b11
	} sms_state_t;

	// Launch edge: the trailing edge with phase clear, the leading edge with it set
	function automatic logic sms_launch(input logic capture_edge_select, input logic lead);
		sms_launch = capture_edge_select ? lead : !lead;
	endfunction : sms_launch

endpackage : sms_pkg

`default_nettype wire

// [tb/sms_link_asserts.sv]
// Purpose: Concurrent checks on the register bus and the serial link.
// Assumes: Partner half period of six cycles.
// Notes:   Watches interface wires and core pins only.
`default_nettype none

module sms_link_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic cpu_mask_i,
	input wire logic irq_o,
	input wire logic ss_n,
	input wire logic sck,
	input wire logic dev_sck_oe_n,
	input wire logic ptn_sck_o,
	input wire logic ptn_sck_oe_n
);
	logic       sck_r;
	logic [4:0] edge_cnt_r;
	logic [4:0] edge_cnt_nxt;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Edges counted only inside a select frame
	always_comb begin
		edge_cnt_nxt = ss_n ? 5'h00 : edge_cnt_r + {4'h0, sck != sck_r};
	end

	always_ff @(posedge clk_i) begin
		sck_r      <= sck;
		edge_cnt_r <= rst_i ? 5'h00 : edge_cnt_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_ack_only_asked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_irq_masked: assert property (cpu_mask_i |-> !irq_o)
		else $error("irq while masked");
	a_irq_holds: assert property (irq_o && !(wb_cyc_i && wb_stb_i) |=> irq_o || cpu_mask_i)
		else $error("irq dropped without bus access");
	a_master_yields: assert property ($fell(ss_n) && !dev_sck_oe_n |-> ##[1:6] dev_sck_oe_n)
		else $error("master kept clock with select low");
	a_ptn_half_period: assert property ($changed(ptn_sck_o) && !ptn_sck_oe_n
		&& !$past(ptn_sck_oe_n) |=> $stable(ptn_sck_o) [*5])
		else $error("partner clock half period short");
	a_sck_in_frame: assert property ($changed(ptn_sck_o) && !ptn_sck_oe_n
		&& !$past(ptn_sck_oe_n) |-> !$past(ss_n))
		else $error("clock edge outside frame");
	a_frame_edges: assert property ($rose(ss_n) |-> edge_cnt_r + {4'h0, sck != sck_r} == 5'h10)
		else $error("frame edge count not sixteen");

	c_ack: cover property (wb_ack_o);
	c_frame: cover property ($rose(ss_n));
	c_irq: cover property ($rose(irq_o));
endmodule : sms_link_asserts

`default_nettype wire

// [tb/tb_sms_core.sv]
// Purpose: Self-checking bench for both ends of the serial link.
// Assumes: Device master at divide by 16, 32 or 64; partner half period six cycles.
// Notes:   Flags are polled over Wishbone, except one wait on partner done plus 8 cycles, before a write made with the flag set.
`default_nettype none
`include "sms_defs.svh"

module tb_sms_core;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic        mask = 1'b0;
	logic        role = 1'b0;
	logic        clock_idle_level = 1'b0;
	logic        capture_edge_select = 1'b0;
	logic        start = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic        ack;
	logic        irq;
	logic        pdone;
	logic [7:0]  prx;
	logic [7:0]  ptx = 8'h00;
	logic [7:0]  q;
	logic [7:0]  c;
	logic [7:0]  t;
	int          errors = 0;
	int          n_tests = 0;

	always #5ns clk_i = !clk_i;

	sms_link_if link ();

	sms_core u_sms_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
		.wb_ack_o(ack), .cpu_mask_i(mask), .irq_o(irq), .link(link.dev));

	sms_partner #(.HALF_RELOAD(8'h05)) u_sms_partner (.clk_i(clk_i), .rst_i(rst_i),
		.role_master_i(role), .clock_idle_level_i(clock_idle_level), .capture_edge_select_i(capture_edge_select), .start_i(start),
		.tx_byte_i(ptx), .rx_byte_o(prx), .done_o(pdone), .busy_o(), .link(link.ptn));

	sms_link_asserts u_sms_link_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_ack_o(ack), .cpu_mask_i(mask), .irq_o(irq), .ss_n(link.ss_n),
		.sck(link.sck), .dev_sck_oe_n(link.dev_sck_oe_n), .ptn_sck_o(link.ptn_sck_o),
		.ptn_sck_oe_n(link.ptn_sck_oe_n));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Request held until the rising edge that samples ack high
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		dat_w <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) chk("ack", 8'h01, {7'h00, ack});
		q = dat_r[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic rd(input string what, input logic [3:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(what, e, q);
	endtask : rd

	// Status reads while both flags are clear do not arm the clear sequence
	task automatic poll(input logic [7:0] e);
		int n;
		n = 0;
		do begin
			wb(1'b0, `SMS_OFF_STAT, 8'h00);
			n++;
		end while (q[7] !== 1'b1 && n < 400);
		chk("status", e, q);
	endtask : poll

	// Role dropped first so a polarity change never shows as a clock edge
	task automatic setp(input logic r, input logic [1:0] m);
		@(posedge clk_i);
		role <= 1'b0;
		repeat (2) @(posedge clk_i);
		clock_idle_level <= m[1];
		capture_edge_select <= m[0];
		repeat (2) @(posedge clk_i);
		role <= r;
		repeat (10) @(posedge clk_i);
	endtask : setp

	task automatic go(input logic [7:0] d);
		@(posedge clk_i);
		start <= 1'b1;
		ptx <= d;
		@(posedge clk_i);
		start <= 1'b0;
	endtask : go

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////////
	initial begin
		#200us;
		chk("watchdog", 8'h00, 8'h01);
		stop_test();
	end

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd("ctrl", `SMS_OFF_CTRL, `SMS_CTRL_RST);
		rd("status", `SMS_OFF_STAT, 8'h00);
		wb(1'b1, `SMS_OFF_STAT, 8'hFF);
		rd("status ro", `SMS_OFF_STAT, 8'h00);
		rd("unmapped", 4'hC, 8'h00);
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			setp(1'b0, m[1:0]);
			// Divide by 16, 32, 64; divide by 2 outruns the partner's synchronisers
			c = 8'hD0 | {4'h0, m[1:0], 2'h0} | ((m == 1) ? 8'h22 : (m == 2) ? 8'h02 : 8'h01);
			t = 8'hA6 - 8'(m * 17);
			wb(1'b1, `SMS_OFF_CTRL, c);
			rd("ctrl", `SMS_OFF_CTRL, c);
			// Partner loaded after the polarity change, so that edge is not counted
			go(8'h1B + 8'(m));
			wb(1'b1, `SMS_OFF_DATA, t);
			wb(1'b1, `SMS_OFF_DATA, 8'h00);
			poll(8'hC0);
			chk("irq", 8'h01, {7'h00, irq});
			@(posedge clk_i);
			mask <= 1'b1;
			@(negedge clk_i);
			chk("irq masked", 8'h00, {7'h00, irq});
			@(posedge clk_i);
			mask <= 1'b0;
			chk("sck idle", {7'h00, m[1]}, {7'h00, link.sck});
			rd("rx", `SMS_OFF_DATA, ptx);
			rd("status clr", `SMS_OFF_STAT, 8'h00);
			chk("far rx", t, prx);
			$display("test master mode %0d done", m);
		end
		// A write while the flag is set must not start a byte
		go(8'h96);
		wb(1'b1, `SMS_OFF_DATA, 8'h3C);
		while (pdone !== 1'b1 && n_tests < 1000) @(negedge clk_i);
		repeat (8) @(posedge clk_i);
		go(8'h4B);
		wb(1'b1, `SMS_OFF_DATA, 8'h5A);
		rd("status", `SMS_OFF_STAT, 8'h80);
		wb(1'b1, `SMS_OFF_DATA, 8'h69);
		poll(8'h80);
		rd("rx", `SMS_OFF_DATA, 8'h4B);
		chk("far rx", 8'h69, prx);
		$display("test flag blocks write done");
		// Select pulled low under a master drops the mode bits
		setp(1'b1, 2'h0);
		wb(1'b1, `SMS_OFF_CTRL, 8'h50);
		go(8'h00);
		repeat (150) @(posedge clk_i);
		rd("ctrl", `SMS_OFF_CTRL, 8'h00);
		wb(1'b0, `SMS_OFF_STAT, 8'h00);
		wb(1'b0, `SMS_OFF_DATA, 8'h00);
		$display("test master select low done");
		for (int m = 0; m < 4; m++) begin
			setp(1'b1, m[1:0]);
			c = 8'h43 | {4'h0, m[1:0], 2'h0};
			t = 8'h2D + 8'(m * 16);
			wb(1'b1, `SMS_OFF_CTRL, c);
			wb(1'b1, `SMS_OFF_DATA, t);
			go(8'hE1 - 8'(m));
			// Selected, before the first edge: frozen with phase clear, loaded with it set
			repeat (3) @(posedge clk_i);
			wb(1'b1, `SMS_OFF_DATA, 8'hFF);
			repeat (20) @(posedge clk_i);
			wb(1'b1, `SMS_OFF_DATA, 8'h00);
			poll(8'hC0);
			chk("irq off", 8'h00, {7'h00, irq});
			rd("rx", `SMS_OFF_DATA, ptx);
			chk("far rx", m[0] ? 8'hFF : t, prx);
			$display("test slave mode %0d done", m);
		end
		stop_test();
	end
endmodule : tb_sms_core

`default_nettype wire
